/* File: core/fsfl_regs.vh */
`ifndef FSFL_REGS_VH
`define FSFL_REGS_VH

// Register byte offsets.
`define FSFL_RX_END_OFS 8'hc8
`define FSFL_TX_END_OFS 8'hcc
`define FSFL_WMARK_OFS 8'hd0
`define FSFL_RX_OCC_OFS 8'hd4
`define FSFL_TX_OCC_OFS 8'hd8
`define FSFL_IDLE_FAST_OFS 8'he0
`define FSFL_IDLE_SLOW_OFS 8'he4
`define FSFL_ACT_FAST_OFS 8'he8
`define FSFL_ACT_SLOW_OFS 8'hec
`define FSFL_SLOW_STEP 8'h04

// Buffer end fields and resets.
`define FSFL_RX_END_W 7
`define FSFL_TX_END_W 6
`define FSFL_RX_END_RST 7'h17
`define FSFL_TX_END_RST 6'h17
`define FSFL_END_LOW_FILL 7'h7f

// Watermark fields.
`define FSFL_WM_W 7
`define FSFL_WM_ON_LSB 0
`define FSFL_WM_OFF_LSB 8
`define FSFL_WM_RST 7'h00
`define FSFL_WM_UNIT_SHIFT 9

// Occupancy fields.
`define FSFL_OCC_W 16
`define FSFL_OCC_TOT_LSB 16
`define FSFL_OCC_MAX 16'hffff

// Latency tolerance fields.
`define FSFL_TOL_W 12
`define FSFL_TOL_HI_LSB 16
`define FSFL_TOL_LO_LSB 0
`define FSFL_TOL_RST 12'h000
`define FSFL_TOL_N 6

// Link speed codes.
`define FSFL_SPD_TEN 2'h0
`define FSFL_SPD_HUNDRED 2'h1
`define FSFL_SPD_GIG 2'h2

`endif

/* File: core/fsfl_core.v */
`timescale 1ns/1ps
`include "fsfl_regs.vh"

module fsfl_core #(
  parameter RX_END_W = `FSFL_RX_END_W,
  parameter TX_END_W = `FSFL_TX_END_W,
  parameter OCC_W = `FSFL_OCC_W,
  parameter TOL_W = `FSFL_TOL_W
) (
  input wire sys_clk,
  input wire rst,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire [OCC_W-1:0] usb_side_rx_bytes,
  input wire [OCC_W-1:0] rx_frame_buffer_bytes,
  input wire [OCC_W-1:0] usb_side_tx_bytes,
  input wire [OCC_W-1:0] tx_frame_buffer_bytes,
  input wire pause_send_enable,
  output reg pause_request,
  output reg [RX_END_W+6:0] rx_buffer_last_dword,
  output reg [TX_END_W+6:0] tx_buffer_last_dword,
  input wire [1:0] link_speed,
  input wire ltm_idle,
  output reg [TOL_W-1:0] tolerance_value,
  input wire image_load,
  input wire image_present,
  input wire [`FSFL_TOL_N*TOL_W-1:0] image_tolerances,
  input wire usb_bus_reset,
  input wire light_soft_reset
);

  // Tolerance field order in the flat vectors below:
  // 0 idle gig, 1 idle hundred, 2 idle ten, 3 active gig, 4 active hundred, 5 active ten.
  localparam NTOL = `FSFL_TOL_N;

  reg [RX_END_W-1:0] rx_end_q;
  reg [TX_END_W-1:0] tx_end_q;
  reg [`FSFL_WM_W-1:0] wm_on_q;
  reg [`FSFL_WM_W-1:0] wm_off_q;
  reg [NTOL*TOL_W-1:0] tol_q;
  reg [NTOL*TOL_W-1:0] image_q;
  reg image_valid_q;
  reg pause_d;
  reg [31:0] rdata_d;
  reg [TOL_W-1:0] tol_sel;
  reg [TOL_W-1:0] idle_sel;
  reg [TOL_W-1:0] act_sel;

  wire wr_rx_end;
  wire wr_tx_end;
  wire wr_wm;
  wire restore;
  // Address decode, one line per register.
  wire hit_rx_end;
  wire hit_tx_end;
  wire hit_wm;
  wire hit_rx_occ;
  wire hit_tx_occ;
  wire hit_idle_fast;
  wire hit_idle_slow;
  wire hit_act_fast;
  wire hit_act_slow;
  // Flow-control mark compares.
  wire at_on_mark;
  wire at_off_mark;
  wire [OCC_W-`FSFL_WM_UNIT_SHIFT-1:0] rx_units;
  wire [OCC_W:0] rx_tot_sum;
  wire [OCC_W:0] tx_tot_sum;
  wire [OCC_W-1:0] rx_tot;
  wire [OCC_W-1:0] tx_tot;
  wire [TOL_W-1:0] idle_gig;
  wire [TOL_W-1:0] idle_hundred;
  wire [TOL_W-1:0] idle_ten;
  wire [TOL_W-1:0] act_gig;
  wire [TOL_W-1:0] act_hundred;
  wire [TOL_W-1:0] act_ten;

  // Read words, assembled once per register.
  wire [31:0] word_rx_end;
  wire [31:0] word_tx_end;
  wire [31:0] word_wmark;
  wire [31:0] word_rx_occ;
  wire [31:0] word_tx_occ;
  wire [31:0] word_idle_fast;
  wire [31:0] word_idle_slow;
  wire [31:0] word_act_fast;
  wire [31:0] word_act_slow;

  // Decode is an exact byte match: an unaligned or partial address hits nothing,
  // so a stray access can never alias onto a neighbouring register.
  assign hit_rx_end = (reg_addr == `FSFL_RX_END_OFS);
  assign hit_tx_end = (reg_addr == `FSFL_TX_END_OFS);
  assign hit_wm = (reg_addr == `FSFL_WMARK_OFS);
  assign hit_rx_occ = (reg_addr == `FSFL_RX_OCC_OFS);
  assign hit_tx_occ = (reg_addr == `FSFL_TX_OCC_OFS);
  assign hit_idle_fast = (reg_addr == `FSFL_IDLE_FAST_OFS);
  assign hit_idle_slow = (reg_addr == `FSFL_IDLE_SLOW_OFS);
  assign hit_act_fast = (reg_addr == `FSFL_ACT_FAST_OFS);
  assign hit_act_slow = (reg_addr == `FSFL_ACT_SLOW_OFS);

  // The occupancy registers have no write path; a write there falls through.
  assign wr_rx_end = reg_wr && hit_rx_end;
  assign wr_tx_end = reg_wr && hit_tx_end;
  assign wr_wm = reg_wr && hit_wm;
  // Either reset source restores the same image; they are not told apart.
  assign restore = usb_bus_reset || light_soft_reset;

  // Buffer end registers; only the field bits are stored.
  // The two ends are kept apart so that resizing one never disturbs the other.
  always @(posedge sys_clk) begin
    if (rst) begin
      rx_end_q <= `FSFL_RX_END_RST;
    end else if (wr_rx_end) begin
      rx_end_q <= reg_wdata[RX_END_W-1:0];
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      tx_end_q <= `FSFL_TX_END_RST;
    end else if (wr_tx_end) begin
      tx_end_q <= reg_wdata[TX_END_W-1:0];
    end
  end

  // The size is applied at once; the datapath is assumed halted while it changes
  // and flushed afterwards, so no attempt is made to relocate stored data.
  always @(posedge sys_clk) begin
    if (rst) begin
      rx_buffer_last_dword <= {`FSFL_RX_END_RST, `FSFL_END_LOW_FILL};
    end else begin
      rx_buffer_last_dword <= {rx_end_q, `FSFL_END_LOW_FILL};
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      tx_buffer_last_dword <= {`FSFL_TX_END_RST, `FSFL_END_LOW_FILL};
    end else begin
      tx_buffer_last_dword <= {tx_end_q, `FSFL_END_LOW_FILL};
    end
  end

  // Watermarks.
  // Each mark is its own register; a write always updates both together.
  always @(posedge sys_clk) begin
    if (rst) begin
      wm_on_q <= `FSFL_WM_RST;
    end else if (wr_wm) begin
      wm_on_q <= reg_wdata[`FSFL_WM_ON_LSB +: `FSFL_WM_W];
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      wm_off_q <= `FSFL_WM_RST;
    end else if (wr_wm) begin
      wm_off_q <= reg_wdata[`FSFL_WM_OFF_LSB +: `FSFL_WM_W];
    end
  end

  // The occupancy input already counts each frame rounded up to a DWORD plus its
  // command words and checksums; this block only compares it.
  assign rx_units = rx_frame_buffer_bytes[OCC_W-1:`FSFL_WM_UNIT_SHIFT];
  // The marks compare whole 512-byte units; a partly filled unit does not count.
  assign at_on_mark = (rx_units >= wm_on_q);
  assign at_off_mark = (rx_units <= wm_off_q);

  // When both marks are met at once (off mark not below the on mark) the on
  // condition wins, so a misprogrammed pair errs toward protecting the buffer.
  always @* begin
    pause_d = pause_request;
    if (!pause_send_enable) begin
      pause_d = 1'b0;
    end else if (at_on_mark) begin
      pause_d = 1'b1;
    end else if (at_off_mark) begin
      pause_d = 1'b0;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      pause_request <= 1'b0;
    end else begin
      pause_request <= pause_d;
    end
  end

  // Totals saturate rather than wrap so a reading never looks emptier than it is.
  assign rx_tot_sum = {1'b0, usb_side_rx_bytes} + {1'b0, rx_frame_buffer_bytes};
  assign tx_tot_sum = {1'b0, usb_side_tx_bytes} + {1'b0, tx_frame_buffer_bytes};
  assign rx_tot = rx_tot_sum[OCC_W] ? `FSFL_OCC_MAX : rx_tot_sum[OCC_W-1:0];
  assign tx_tot = tx_tot_sum[OCC_W] ? `FSFL_OCC_MAX : tx_tot_sum[OCC_W-1:0];

  // Latency tolerance image shadow: remembers the last loaded image for restores.
  always @(posedge sys_clk) begin
    if (rst) begin
      image_valid_q <= 1'b0;
      image_q <= {NTOL*TOL_W{1'b0}};
    end else if (image_load) begin
      image_valid_q <= image_present;
      image_q <= image_present ? image_tolerances : {NTOL*TOL_W{1'b0}};
    end
  end

  // One field per generate entry; address and position follow the field order.
  genvar k;
  generate
    for (k = 0; k < NTOL; k = k + 1) begin : g_tol
      localparam [7:0] BASE = (k < 3) ? `FSFL_IDLE_FAST_OFS : `FSFL_ACT_FAST_OFS;
      localparam [7:0] ADDR = ((k % 3) == 2) ? BASE + `FSFL_SLOW_STEP : BASE;
      localparam LSB = ((k % 3) == 0) ? `FSFL_TOL_HI_LSB : `FSFL_TOL_LO_LSB;
      wire wr_hit;
      wire [TOL_W-1:0] load_val;
      wire [TOL_W-1:0] restore_val;
      assign wr_hit = reg_wr && (reg_addr == ADDR);
      assign load_val = image_present ? image_tolerances[k*TOL_W +: TOL_W] : `FSFL_TOL_RST;
      assign restore_val = image_valid_q ? image_q[k*TOL_W +: TOL_W] : `FSFL_TOL_RST;
      // A reload from the image beats a software write in the same cycle,
      // so a reset arriving with an access cannot leave a half-written field.
      always @(posedge sys_clk) begin
        if (rst) begin
          tol_q[k*TOL_W +: TOL_W] <= `FSFL_TOL_RST;
        end else if (image_load) begin
          tol_q[k*TOL_W +: TOL_W] <= load_val;
        end else if (restore) begin
          tol_q[k*TOL_W +: TOL_W] <= restore_val;
        end else if (wr_hit) begin
          tol_q[k*TOL_W +: TOL_W] <= reg_wdata[LSB +: TOL_W];
        end
      end
    end
  endgenerate

  assign idle_gig = tol_q[0*TOL_W +: TOL_W];
  assign idle_hundred = tol_q[1*TOL_W +: TOL_W];
  assign idle_ten = tol_q[2*TOL_W +: TOL_W];
  assign act_gig = tol_q[3*TOL_W +: TOL_W];
  assign act_hundred = tol_q[4*TOL_W +: TOL_W];
  assign act_ten = tol_q[5*TOL_W +: TOL_W];

  // Speed is resolved within each state first, then the state picks between the two.
  // An unknown speed code falls back to the slowest value.
  always @* begin
    idle_sel = idle_ten;
    case (link_speed)
      `FSFL_SPD_GIG: begin
        idle_sel = idle_gig;
      end
      `FSFL_SPD_HUNDRED: begin
        idle_sel = idle_hundred;
      end
      `FSFL_SPD_TEN: begin
        idle_sel = idle_ten;
      end
      default: begin
        idle_sel = idle_ten;
      end
    endcase
  end

  always @* begin
    act_sel = act_ten;
    case (link_speed)
      `FSFL_SPD_GIG: begin
        act_sel = act_gig;
      end
      `FSFL_SPD_HUNDRED: begin
        act_sel = act_hundred;
      end
      `FSFL_SPD_TEN: begin
        act_sel = act_ten;
      end
      default: begin
        act_sel = act_ten;
      end
    endcase
  end

  always @* begin
    tol_sel = ltm_idle ? idle_sel : act_sel;
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      tolerance_value <= `FSFL_TOL_RST;
    end else begin
      tolerance_value <= tol_sel;
    end
  end

  // Whole read words; reserved bits are tied to zero here, once, for every register.
  assign word_rx_end = {{(32-RX_END_W){1'b0}}, rx_end_q};
  assign word_tx_end = {{(32-TX_END_W){1'b0}}, tx_end_q};
  assign word_wmark = {{(32-`FSFL_WM_OFF_LSB-`FSFL_WM_W){1'b0}}, wm_off_q,
    {(`FSFL_WM_OFF_LSB-`FSFL_WM_W){1'b0}}, wm_on_q};
  assign word_rx_occ = {rx_tot, usb_side_rx_bytes};
  assign word_tx_occ = {tx_tot, usb_side_tx_bytes};
  assign word_idle_fast = {{(32-`FSFL_TOL_HI_LSB-TOL_W){1'b0}}, idle_gig,
    {(`FSFL_TOL_HI_LSB-TOL_W){1'b0}}, idle_hundred};
  assign word_idle_slow = {{(32-TOL_W){1'b0}}, idle_ten};
  assign word_act_fast = {{(32-`FSFL_TOL_HI_LSB-TOL_W){1'b0}}, act_gig,
    {(`FSFL_TOL_HI_LSB-TOL_W){1'b0}}, act_hundred};
  assign word_act_slow = {{(32-TOL_W){1'b0}}, act_ten};

  // Read select; an unmapped address leaves the word at zero.
  always @* begin
    rdata_d = 32'h00000000;
    if (hit_rx_end) begin
      rdata_d = word_rx_end;
    end
    if (hit_tx_end) begin
      rdata_d = word_tx_end;
    end
    if (hit_wm) begin
      rdata_d = word_wmark;
    end
    if (hit_rx_occ) begin
      rdata_d = word_rx_occ;
    end
    if (hit_tx_occ) begin
      rdata_d = word_tx_occ;
    end
    if (hit_idle_fast) begin
      rdata_d = word_idle_fast;
    end
    if (hit_idle_slow) begin
      rdata_d = word_idle_slow;
    end
    if (hit_act_fast) begin
      rdata_d = word_act_fast;
    end
    if (hit_act_slow) begin
      rdata_d = word_act_slow;
    end
  end

  // Read data stand only in the cycle after the strobe, zero otherwise.
  always @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule

/* File: verification/fsfl_core_asserts.sv */
`timescale 1ns/1ps
module fsfl_chk (
  input wire sys_clk,
  input wire rst,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  input wire [15:0] usb_side_rx_bytes,
  input wire [15:0] rx_frame_buffer_bytes,
  input wire [15:0] usb_side_tx_bytes,
  input wire pause_send_enable,
  input wire pause_request,
  input wire [13:0] rx_buffer_last_dword,
  input wire [12:0] tx_buffer_last_dword
);
  // Shadow of the watermarks, since the checker cannot see the register itself.
  reg [6:0] on_q;
  reg [6:0] off_q;
  reg [16:0] sum_q;
  reg rst_q;
  wire [6:0] units = rx_frame_buffer_bytes[15:9];
  always @(posedge sys_clk) begin
    rst_q <= rst;
    sum_q <= usb_side_rx_bytes + rx_frame_buffer_bytes;
    if (rst) begin
      on_q <= 7'h00;
      off_q <= 7'h00;
    end else if (reg_wr && reg_addr == 8'hd0) begin
      on_q <= reg_wdata[6:0];
      off_q <= reg_wdata[14:8];
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_read_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("stray read data");
  a_rx_occ_low: assert property ($past(reg_rd) && $past(reg_addr) == 8'hd4 |->
    reg_rdata[15:0] == $past(usb_side_rx_bytes)) else $error("rx usb occupancy wrong");
  a_rx_occ_total: assert property ($past(reg_rd) && $past(reg_addr) == 8'hd4 |->
    reg_rdata[31:16] == (sum_q[16] ? 16'hffff : sum_q[15:0])) else $error("rx total occupancy wrong");
  a_tx_occ_low: assert property ($past(reg_rd) && $past(reg_addr) == 8'hd8 |->
    reg_rdata[15:0] == $past(usb_side_tx_bytes)) else $error("tx usb occupancy wrong");
  a_pause_disabled: assert property (!rst_q && !$past(pause_send_enable) |-> !pause_request)
    else $error("pause while disabled");
  a_pause_on_mark: assert property (!rst_q && $past(pause_send_enable) && $past(units) >= $past(on_q) |->
    pause_request) else $error("pause not raised");
  a_pause_off_mark: assert property (!rst_q && $past(pause_send_enable) && $past(units) < $past(on_q)
    && $past(units) <= $past(off_q) |-> !pause_request) else $error("pause not released");
  a_pause_hold_band: assert property (!rst_q && $past(pause_send_enable) && $past(units) < $past(on_q)
    && $past(units) > $past(off_q) |-> $stable(pause_request)) else $error("pause changed in band");
  a_rx_end_out: assert property (!rst_q && $past(reg_wr, 2) && $past(reg_addr, 2) == 8'hc8 |->
    rx_buffer_last_dword == {$past(reg_wdata[6:0], 2), 7'h7f}) else $error("rx last dword wrong");
  a_tx_end_out: assert property (!rst_q && $past(reg_wr, 2) && $past(reg_addr, 2) == 8'hcc |->
    tx_buffer_last_dword == {$past(reg_wdata[5:0], 2), 7'h7f}) else $error("tx last dword wrong");
  a_tx_low_fill: assert property (tx_buffer_last_dword[6:0] == 7'h7f) else $error("tx last dword fill");
endmodule
bind fsfl_core fsfl_chk u_chk (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .usb_side_rx_bytes(usb_side_rx_bytes),
  .rx_frame_buffer_bytes(rx_frame_buffer_bytes), .usb_side_tx_bytes(usb_side_tx_bytes),
  .pause_send_enable(pause_send_enable), .pause_request(pause_request),
  .rx_buffer_last_dword(rx_buffer_last_dword), .tx_buffer_last_dword(tx_buffer_last_dword));

/* File: verification/fsfl_core_bench.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module fsfl_core_bench;
  reg sys_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, pause_send_enable = 0, ltm_idle = 0, rd_q = 0;
  reg image_load = 0, image_present = 0, usb_bus_reset = 0, light_soft_reset = 0;
  reg [7:0] reg_addr = 8'h00;
  reg [31:0] reg_wdata = 32'h0, e;
  reg [15:0] usb_tx_side_buffer = 16'h0, frx = 16'h0, usb_rx_side_buffer = 16'h0, ftx = 16'h0;
  reg [1:0] link_speed = 2'h0;
  reg [71:0] img = 72'h0;
  reg [11:0] t [0:5];
  reg [31:0] exp_q [$];
  wire [31:0] reg_rdata;
  wire pause_request;
  wire [13:0] rx_last;
  wire [12:0] tx_last;
  wire [11:0] tol;
  integer err_count = 0, checked = 0, i, k;
  always #2.5 sys_clk = ~sys_clk;
  fsfl_core u_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .usb_side_rx_bytes(usb_tx_side_buffer), .rx_frame_buffer_bytes(frx),
    .usb_side_tx_bytes(usb_rx_side_buffer), .tx_frame_buffer_bytes(ftx), .pause_send_enable(pause_send_enable),
    .pause_request(pause_request), .rx_buffer_last_dword(rx_last), .tx_buffer_last_dword(tx_last),
    .link_speed(link_speed), .ltm_idle(ltm_idle), .tolerance_value(tol), .image_load(image_load),
    .image_present(image_present), .image_tolerances(img), .usb_bus_reset(usb_bus_reset),
    .light_soft_reset(light_soft_reset));
  task test_done;
    $display("Mismatches %0d, comparisons %0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task wr(input [7:0] a, input [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    @(posedge sys_clk);
  endtask
  task rd(input [7:0] a, input [31:0] x);
    reg_addr <= a;
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    exp_q.push_back(x);
    @(posedge sys_clk);
  endtask
  task idle(input integer n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge sys_clk);
  endtask
  function [31:0] tolw(input integer r);
    integer b;
    begin
      b = (r / 2) * 3;
      tolw = r[0] ? {20'h0, t[b+2]} : {4'h0, t[b], 4'h0, t[b+1]};
    end
  endfunction
  function [31:0] occ(input [15:0] u, input [15:0] f);
    reg [16:0] s;
    begin
      s = u + f;
      occ = {s[16] ? 16'hffff : s[15:0], u};
    end
  endfunction
  task chk_tol;
    for (k = 0; k < 4; k++) rd(8'he0 + 8'(k * 4), tolw(k));
    idle(3);
  endtask
  task fc(input [15:0] b, input en, input x);
    frx <= b;
    pause_send_enable <= en;
    idle(2);
    `CHK(pause_request, x)
  endtask
  // Read answers are matched in order against what the driver noted.
  always @(posedge sys_clk) begin
    rd_q <= reg_rd;
    if (rd_q) begin
      e = exp_q.pop_front();
      `CHK(reg_rdata, e)
    end
  end
  initial begin
    #20000;
    err_count++;
    test_done;
  end
  initial begin
    i = $urandom(37);
    for (k = 0; k < 6; k++) t[k] = 12'h000;
    {usb_tx_side_buffer, frx} <= $urandom;
    {usb_rx_side_buffer, ftx} <= $urandom;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    `CHK(rx_last, 14'hbff)
    `CHK(tx_last, 13'hbff)
    rd(8'hc8, 32'h17);
    rd(8'hcc, 32'h17);
    rd(8'hd0, 32'h0);
    chk_tol;
    for (k = 0; k < 6; k++) t[k] = 12'hfff;
    for (k = 0; k < 4; k++) wr(8'he0 + 8'(k * 4), 32'hffffffff);
    wr(8'hc8, 32'hffffffff);
    wr(8'hcc, 32'hffffffff);
    wr(8'hd0, 32'hffffffff);
    wr(8'hd4, 32'hffffffff);
    wr(8'hd8, 32'hffffffff);
    wr(8'hdc, 32'hffffffff);
    rd(8'hc8, 32'h7f);
    rd(8'hcc, 32'h3f);
    rd(8'hd0, 32'h7f7f);
    rd(8'hdc, 32'h0);
    chk_tol;
    `CHK(rx_last, 14'h3fff)
    `CHK(tx_last, 13'h1fff)
    wr(8'hc8, 32'h5);
    idle(2);
    `CHK(rx_last, {7'h05, 7'h7f})
    for (i = 0; i < 16; i++) begin
      {usb_tx_side_buffer, frx} <= $urandom;
      {usb_rx_side_buffer, ftx} <= (i == 0) ? 32'hffff0001 : $urandom;
      idle(1);
      rd(8'hd4, occ(usb_tx_side_buffer, frx));
      rd(8'hd8, occ(usb_rx_side_buffer, ftx));
    end
    wr(8'hd0, 32'h0204);
    fc(16'd2048, 1'b1, 1'b1);
    fc(16'd1536, 1'b1, 1'b1);
    fc(16'd1024, 1'b1, 1'b0);
    fc(16'd2047, 1'b1, 1'b0);
    fc(16'hffff, 1'b1, 1'b1);
    fc(16'hffff, 1'b0, 1'b0);
    for (k = 0; k < 6; k++) t[k] = 12'($urandom);
    for (i = 0; i < 4; i++) wr(8'he0 + 8'(i * 4), tolw(i));
    for (i = 0; i < 8; i++) begin
      link_speed <= i[1:0];
      ltm_idle <= i[2];
      idle(2);
      `CHK(tol, t[(i[2] ? 0 : 3) + (i[1:0] == 2'h2 ? 0 : i[1:0] == 2'h1 ? 1 : 2)])
    end
    img <= {8'($urandom), $urandom, $urandom};
    image_present <= 1'b1;
    image_load <= 1'b1;
    idle(1);
    image_load <= 1'b0;
    for (k = 0; k < 6; k++) t[k] = img[k*12+:12];
    chk_tol;
    for (i = 0; i < 4; i++) wr(8'he0 + 8'(i * 4), 32'h0);
    usb_bus_reset <= 1'b1;
    idle(1);
    usb_bus_reset <= 1'b0;
    chk_tol;
    image_present <= 1'b0;
    image_load <= 1'b1;
    idle(1);
    image_load <= 1'b0;
    for (i = 0; i < 4; i++) wr(8'he0 + 8'(i * 4), 32'hffffffff);
    light_soft_reset <= 1'b1;
    idle(1);
    light_soft_reset <= 1'b0;
    for (k = 0; k < 6; k++) t[k] = 12'h000;
    chk_tol;
    test_done;
  end
endmodule
